// ==== cpo_pkg.sv ====
/*
  Shared constants and carrier types for the control and pointer core.
  Assumes a 14-bit instruction word and an 8-bit data path.
*/
package cpo_pkg;
  // Widths and depths.
  localparam int PC_W = 15;
  localparam int STK_D = 16;
  // Exact instruction codes.
  localparam logic [13:0] OP_IDLE = 14'h0000;
  localparam logic [13:0] OP_RESTART = 14'h0001;
  localparam logic [13:0] OP_RET = 14'h0008;
  localparam logic [13:0] OP_RETI = 14'h0009;
  localparam logic [13:0] OP_CALLA = 14'h000a;
  localparam logic [13:0] OP_BRA_ACC = 14'h000b;
  localparam logic [13:0] OP_TMRCFG = 14'h0062;
  localparam logic [13:0] OP_STANDBY = 14'h0063;
  localparam logic [13:0] OP_WDCLR = 14'h0064;
  // Prefix codes, compared against the top bits of the word.
  localparam logic [4:0] PF_BRA = 5'h19;
  localparam logic [2:0] PF_CALL = 3'h4;
  localparam logic [2:0] PF_JMP = 3'h5;
  localparam logic [5:0] PF_RETL = 6'h34;
  localparam logic [6:0] PF_PADD = 7'h62;
  localparam logic [10:0] PF_IRD = 11'h002;
  localparam logic [10:0] PF_IWR = 11'h003;
  localparam logic [10:0] PF_DIR = 11'h00c;
  localparam logic [6:0] PF_XRD = 7'h7e;
  localparam logic [6:0] PF_XWR = 7'h7f;
  localparam logic [5:0] PF_ANDL = 6'h39;
  localparam logic [5:0] PF_ADDL = 6'h3e;
  localparam logic [5:0] PF_ANDF = 6'h05;
  // Pointer update modes.
  localparam logic [1:0] UPD_PREINC = 2'h0;
  localparam logic [1:0] UPD_PREDEC = 2'h1;
  localparam logic [1:0] UPD_POSTINC = 2'h2;
  localparam logic [1:0] UPD_POSTDEC = 2'h3;
  // Register port offsets and reset values.
  localparam logic [1:0] REG_CTRL = 2'h0;
  localparam logic [1:0] REG_ACC = 2'h1;
  localparam logic [1:0] REG_FLAGS = 2'h2;
  localparam logic [1:0] REG_PCLO = 2'h3;
  localparam logic [7:0] CTRL_RST = 8'h01;
  localparam int CTRL_RUN_BIT = 0;

  // Core sequencing states, one-hot.
  typedef enum logic [3:0] {
    ST_EXEC  = 4'h1,
    ST_FLUSH = 4'h2,
    ST_STALL = 4'h4,
    ST_SLEEP = 4'h8
  } cpo_state_t;

  // Status bits; timeout and powerdown are active low as in the core.
  typedef struct packed {
    logic to;
    logic pd;
    logic z;
    logic dc;
    logic c;
  } cpo_flags_t;

  localparam cpo_flags_t FLAGS_RST = '{to: 1'b1, pd: 1'b1, z: 1'b0, dc: 1'b0, c: 1'b0};

  // One data memory access.
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        we;
    logic        re;
  } cpo_mem_req_t;
endpackage : cpo_pkg

// ==== cpo_core.sv ====
/*
  Control-flow, inherent, pointer and accumulator execute logic.
  Assumes program memory answers prog_addr in the same cycle, and data
  memory answers mem_req in the same cycle on mem_rdata.
*/
// Implementation choices: the register offsets and the plain strobed port.
// Overview of operation
// RQ1 - Relative branches decoded, two cycles each.
// RQ2 - Call and jump with 11-bit target.
// RQ3 - Returns decoded, literal return loads accumulator.
// RQ4 - Standby and watchdog clear set status flags.
// RQ5 - Idle, soft restart, timer config load.
// RQ6 - Pin direction load from accumulator.
// RQ7 - Program counter change costs idle cycle; soft restart loads pc 0 with no idle cycle.
// RQ8 - High pointer through window adds cycle; the file form decides the stall on pointer 0 plus one or pointer 1 minus one.
// RQ9 - Pointer add signed six-bit literal.
// RQ10 - Pointers wrap modulo two to sixteen.
// RQ11 - Indirect read with update sets zero.
// RQ12 - Indexed indirect read sets zero.
// RQ13 - Indirect write with update, flags kept.
// RQ14 - Indexed indirect write, flags kept.
// RQ15 - AND literal updates zero only.
// RQ16 - Add literal updates carry, nibble, zero.
// RQ17 - AND file to accumulator or file.
// RQ18 - Branch target is pc plus one plus k.
// RQ19 - Accumulator branch adds unsigned accumulator.
// RQ20 - Update mode selects pre/post inc/dec.
// RQ21 - Calls push, returns pop the stack.
// RQ22 - Unknown words run as idle.
`timescale 1ns/1ps
module cpo_core (
  // Clock and reset.
  input  wire logic                    mclk,
  input  wire logic                    rst,
  // Program memory.
  output logic [cpo_pkg::PC_W-1:0]     prog_addr,
  input  wire logic [13:0]             instr,
  // Data memory.
  output cpo_pkg::cpo_mem_req_t        mem_req,
  input  wire logic [7:0]              mem_rdata,
  // Register port.
  input  wire logic [1:0]              reg_addr,
  input  wire logic [7:0]              reg_wdata,
  input  wire logic                    reg_wr,
  input  wire logic                    reg_rd,
  output logic [7:0]                   reg_rdata,
  // Side effects towards the rest of the chip.
  input  wire logic                    wake,
  output logic                         wdt_clear,
  output logic                         restart,
  output logic                         sleeping,
  output logic [7:0]                   timer_cfg,
  output logic [7:0][7:0]              pin_dir
);

  // Sign-extends a six-bit literal to pointer width.
  function automatic logic [15:0] sext6(input logic [5:0] k);
    sext6 = {{10{k[5]}}, k};
  endfunction : sext6

  cpo_pkg::cpo_state_t              st_q;      // Sequencing state.
  logic [cpo_pkg::PC_W-1:0]         pc_q;      // Address being fetched.
  logic [7:0]                       acc_q;     // Accumulator.
  cpo_pkg::cpo_flags_t              fl_q;      // Status bits.
  logic [1:0][15:0]                 ptr_q;     // Pointer pairs.
  logic [cpo_pkg::STK_D-1:0][cpo_pkg::PC_W-1:0] stk_q; // Return stack.
  logic [3:0]                       sp_q;      // Next free stack slot.
  logic [7:0]                       ctrl_q;    // Software control byte.
  logic [7:0]                       rdat_q;    // Register read data.
  logic                             wdc_q;     // Watchdog clear pulse.
  logic                             rst_q;     // Restart pulse.
  logic [7:0]                       tmr_q;     // Timer configuration.
  logic [7:0][7:0]                  dir_q;     // Pin direction bytes.

  // Decode of the word on the fetch bus.
  logic d_bra, d_brw, d_call, d_calw, d_jmp, d_retl, d_ret, d_reti;
  logic d_sby, d_wdc, d_rsx, d_tmr, d_dir, d_padd;
  logic d_ird, d_iwr, d_xrd, d_xwr, d_andl, d_addl, d_andf;

  always_comb begin
    d_bra  = instr[13:9] == cpo_pkg::PF_BRA;  // RQ1
    d_brw  = instr == cpo_pkg::OP_BRA_ACC;     // RQ1
    d_call = instr[13:11] == cpo_pkg::PF_CALL; // RQ2
    d_jmp  = instr[13:11] == cpo_pkg::PF_JMP;  // RQ2
    d_calw = instr == cpo_pkg::OP_CALLA;       // RQ2
    d_retl = instr[13:8] == cpo_pkg::PF_RETL;  // RQ3
    d_reti = instr == cpo_pkg::OP_RETI;        // RQ3
    d_ret  = instr == cpo_pkg::OP_RET;         // RQ3
    d_sby  = instr == cpo_pkg::OP_STANDBY;     // RQ4
    d_wdc  = instr == cpo_pkg::OP_WDCLR;       // RQ4
    d_rsx  = instr == cpo_pkg::OP_RESTART;     // RQ5
    d_tmr  = instr == cpo_pkg::OP_TMRCFG;      // RQ5
    // Exact inherent codes share the direction-load space, so they win.
    d_dir  = instr[13:3] == cpo_pkg::PF_DIR && !d_sby && !d_wdc && !d_tmr; // RQ6
    d_padd = instr[13:7] == cpo_pkg::PF_PADD;  // RQ9
    d_ird  = instr[13:3] == cpo_pkg::PF_IRD;   // RQ11
    d_iwr  = instr[13:3] == cpo_pkg::PF_IWR;   // RQ13
    d_xrd  = instr[13:7] == cpo_pkg::PF_XRD;   // RQ12
    d_xwr  = instr[13:7] == cpo_pkg::PF_XWR;   // RQ14
    d_andl = instr[13:8] == cpo_pkg::PF_ANDL;  // RQ15
    d_addl = instr[13:8] == cpo_pkg::PF_ADDL;  // RQ16
    d_andf = instr[13:8] == cpo_pkg::PF_ANDF;  // RQ17
  end

  // Pointer selection and update arithmetic.
  logic        psel;
  logic [15:0] pcur, pupd, paddr;
  logic        win, need_stall, ex;
  always_comb begin
    psel = d_andf ? instr[0] : instr[2];
    if (d_xrd || d_xwr || d_padd) begin
      psel = instr[6];
    end
    pcur = ptr_q[psel];
    // Wraps naturally at 16 bits.
    unique case (instr[1:0])
      cpo_pkg::UPD_PREINC, cpo_pkg::UPD_POSTINC: pupd = pcur + 16'h0001; // RQ20 RQ10
      default: pupd = pcur - 16'h0001; // RQ20 RQ10
    endcase
    if (d_xrd || d_xwr) begin
      paddr = pcur + sext6(instr[5:0]); // RQ12 RQ14 RQ10
    end else if (instr[1:0] == cpo_pkg::UPD_PREINC || instr[1:0] == cpo_pkg::UPD_PREDEC) begin
      paddr = pupd; // RQ20
    end else begin
      paddr = pcur;
    end
    // Accesses through a pointer window; the file form uses f of 0 or 1.
    win = d_ird || d_iwr || d_xrd || d_xwr || (d_andf && instr[6:1] == 6'h00);
    need_stall = win && paddr[15] && st_q == cpo_pkg::ST_EXEC; // RQ8
    ex = (st_q == cpo_pkg::ST_EXEC && !need_stall) || st_q == cpo_pkg::ST_STALL;
  end

  // Data memory request; strobes idle in flush, sleep and stall-entry cycles, not in reset or with the run bit clear.
  always_comb begin
    mem_req = '0;
    if (win) begin
      mem_req.addr = d_andf ? pcur : paddr;
    end else begin
      mem_req.addr = {9'h000, instr[6:0]};
    end
    mem_req.wdata = acc_q;
    mem_req.re = ex && (d_ird || d_xrd || d_andf);
    mem_req.we = ex && (d_iwr || d_xwr || (d_andf && instr[7])); // RQ13 RQ14 RQ17
    if (d_andf) begin
      mem_req.wdata = acc_q & mem_rdata; // RQ17
    end
  end

  // Sum for literal add, with nibble carry.
  logic [8:0] sum;
  logic [4:0] nsum;
  always_comb begin
    sum = {1'b0, acc_q} + {1'b0, instr[7:0]};
    nsum = {1'b0, acc_q[3:0]} + {1'b0, instr[3:0]};
  end

  // Sequencing: flush after branches, calls, jumps and returns (not restart), stall for high pointers, sleep.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st_q <= cpo_pkg::ST_EXEC;
    end else begin
      unique case (st_q)
        cpo_pkg::ST_EXEC, cpo_pkg::ST_STALL: begin
          if (!ctrl_q[cpo_pkg::CTRL_RUN_BIT]) begin
            st_q <= st_q;
          end else if (need_stall) begin
            st_q <= cpo_pkg::ST_STALL; // RQ8
          end else if (d_bra || d_brw || d_call || d_calw || d_jmp ||
                       d_retl || d_ret || d_reti) begin
            st_q <= cpo_pkg::ST_FLUSH; // RQ7
          end else if (d_sby) begin
            st_q <= cpo_pkg::ST_SLEEP; // RQ4
          end else begin
            // Undecoded words fall through here and cost one plain cycle.
            st_q <= cpo_pkg::ST_EXEC; // RQ22
          end
        end
        cpo_pkg::ST_FLUSH: st_q <= cpo_pkg::ST_EXEC; // RQ7
        cpo_pkg::ST_SLEEP: st_q <= wake ? cpo_pkg::ST_EXEC : cpo_pkg::ST_SLEEP;
      endcase
    end
  end

  logic run_ex;
  assign run_ex = ex && ctrl_q[cpo_pkg::CTRL_RUN_BIT];

  // Program counter, return stack; the flush cycle fetches nothing useful.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pc_q <= '0;
      sp_q <= 4'h0;
      stk_q <= '0;
    end else if (run_ex && d_rsx) begin
      pc_q <= '0;
      sp_q <= 4'h0;
    end else if (run_ex) begin
      pc_q <= pc_q + 15'h0001;
      if (d_bra) begin
        pc_q <= pc_q + 15'h0001 + {{6{instr[8]}}, instr[8:0]}; // RQ18
      end
      if (d_brw) begin
        pc_q <= pc_q + 15'h0001 + {7'h00, acc_q}; // RQ19
      end
      if (d_jmp || d_call) begin
        pc_q <= {pc_q[14:11], instr[10:0]}; // RQ2
      end
      if (d_calw) begin
        pc_q <= {pc_q[14:8], acc_q}; // RQ2
      end
      if (d_call || d_calw) begin
        stk_q[sp_q] <= pc_q + 15'h0001; // RQ21
        sp_q <= sp_q + 4'h1;
      end
      if (d_retl || d_ret || d_reti) begin
        pc_q <= stk_q[sp_q - 4'h1]; // RQ21 RQ3
        sp_q <= sp_q - 4'h1;
      end
    end
  end

  // Accumulator and status bits.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      acc_q <= 8'h00;
      fl_q <= cpo_pkg::FLAGS_RST;
    end else if (run_ex && d_rsx) begin
      acc_q <= 8'h00;
      fl_q <= cpo_pkg::FLAGS_RST;
    end else if (run_ex) begin
      if (d_retl) begin
        acc_q <= instr[7:0]; // RQ3
      end
      if (d_sby) begin
        fl_q.to <= 1'b1; // RQ4
        fl_q.pd <= 1'b0;
      end
      if (d_wdc) begin
        fl_q.to <= 1'b1; // RQ4
        fl_q.pd <= 1'b1;
      end
      if (d_ird || d_xrd) begin
        acc_q <= mem_rdata; // RQ11 RQ12
        fl_q.z <= mem_rdata == 8'h00;
      end
      if (d_andl) begin
        acc_q <= acc_q & instr[7:0]; // RQ15
        fl_q.z <= (acc_q & instr[7:0]) == 8'h00;
      end
      if (d_addl) begin
        acc_q <= sum[7:0]; // RQ16
        fl_q.c <= sum[8];
        fl_q.dc <= nsum[4];
        fl_q.z <= sum[7:0] == 8'h00;
      end
      if (d_andf) begin
        if (!instr[7]) begin
          acc_q <= acc_q & mem_rdata; // RQ17
        end
        fl_q.z <= (acc_q & mem_rdata) == 8'h00;
      end
    end
  end

  // Pointer pairs: literal add and pre/post update.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ptr_q <= '0;
    end else if (run_ex && d_rsx) begin
      ptr_q <= '0;
    end else if (run_ex && d_padd) begin
      ptr_q[psel] <= pcur + sext6(instr[5:0]); // RQ9 RQ10
    end else if (run_ex && (d_ird || d_iwr)) begin
      ptr_q[psel] <= pupd; // RQ11 RQ13
    end
  end

  // Timer configuration and pin direction bytes, plus side-effect pulses.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      tmr_q <= 8'h00;
      dir_q <= '0;
      wdc_q <= 1'b0;
      rst_q <= 1'b0;
    end else begin
      wdc_q <= run_ex && d_wdc;
      rst_q <= run_ex && d_rsx; // RQ5
      if (run_ex && d_tmr) begin
        tmr_q <= acc_q; // RQ5
      end
      if (run_ex && d_dir) begin
        dir_q[instr[2:0]] <= acc_q; // RQ6
      end
    end
  end

  // Register port: control byte written, state read a cycle later.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ctrl_q <= cpo_pkg::CTRL_RST;
      rdat_q <= 8'h00;
    end else begin
      if (reg_wr && reg_addr == cpo_pkg::REG_CTRL) begin
        ctrl_q <= reg_wdata;
      end
      rdat_q <= 8'h00;
      if (reg_rd) begin
        unique case (reg_addr)
          cpo_pkg::REG_CTRL: rdat_q <= ctrl_q;
          cpo_pkg::REG_ACC: rdat_q <= acc_q;
          cpo_pkg::REG_FLAGS: rdat_q <= {3'h0, fl_q};
          cpo_pkg::REG_PCLO: rdat_q <= pc_q[7:0];
        endcase
      end
    end
  end

  assign prog_addr = pc_q;
  assign reg_rdata = rdat_q;
  assign wdt_clear = wdc_q;
  assign restart = rst_q;
  assign sleeping = st_q == cpo_pkg::ST_SLEEP;
  assign timer_cfg = tmr_q;
  assign pin_dir = dir_q;

  // Checks on the executed behaviour.
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  AST_BRA_TWO: assert property (run_ex && d_bra |=> st_q == cpo_pkg::ST_FLUSH ##1 st_q == cpo_pkg::ST_EXEC) // RQ1
    else $error("Relative branch did not take two cycles.");
  AST_BRA_TGT: assert property (run_ex && d_bra |=> pc_q == $past(pc_q) + 15'h0001
      + {{6{$past(instr[8])}}, $past(instr[8:0])}) // RQ18
    else $error("Relative branch target wrong.");
  AST_CALL_RET: assert property (run_ex && d_call |=> sp_q == $past(sp_q) + 4'h1
      && stk_q[$past(sp_q)] == $past(pc_q) + 15'h0001) // RQ21
    else $error("Call did not push the return address.");
  AST_STANDBY: assert property (run_ex && d_sby |=> fl_q.to && !fl_q.pd && sleeping) // RQ4
    else $error("Standby flags or state wrong.");
  AST_DIR: assert property (run_ex && d_dir |=> pin_dir[$past(instr[2:0])] == $past(acc_q)
      && fl_q == $past(fl_q)) // RQ6
    else $error("Pin direction load wrong.");
  AST_STALL: assert property (ctrl_q[0] && need_stall |=> st_q == cpo_pkg::ST_STALL
      && pc_q == $past(pc_q)) // RQ8
    else $error("High pointer access did not stall.");
  AST_ANDL: assert property (run_ex && d_andl |=> acc_q == ($past(acc_q) & $past(instr[7:0]))
      && fl_q.c == $past(fl_q.c)) // RQ15
    else $error("AND literal result wrong.");
  AST_IWR_FLAGS: assert property (run_ex && (d_iwr || d_xwr) |=> fl_q == $past(fl_q)) // RQ13
    else $error("Indirect write changed status.");
  AST_PADD: assert property (run_ex && d_padd |=> ptr_q[$past(psel)]
      == $past(pcur) + sext6($past(instr[5:0]))) // RQ9
    else $error("Pointer add result wrong.");
  AST_IDLE: assert property (run_ex && instr == cpo_pkg::OP_IDLE |=> pc_q == $past(pc_q)
      + 15'h0001 && acc_q == $past(acc_q) && st_q == cpo_pkg::ST_EXEC) // RQ22
    else $error("Idle changed state.");

  COV_CALL: cover property (run_ex && d_call ##2 run_ex && d_ret);
  COV_STALL: cover property (st_q == cpo_pkg::ST_STALL);
  COV_SLEEP: cover property (sleeping ##1 !sleeping);
endmodule : cpo_core

// ==== cpo_mem_model.sv ====
/*
  Program and data memory model that sits across from the control core.
  Assumes the core reads both memories combinationally in the same cycle
  and that the bench fills the arrays while the core is held in reset.
*/
`timescale 1ns/1ps
module cpo_mem_model (
  // Clock.
  input  wire logic                     mclk,
  // Program side.
  input  wire logic [cpo_pkg::PC_W-1:0] prog_addr,
  output logic [13:0]                   instr,
  // Data side.
  input  wire cpo_pkg::cpo_mem_req_t    mem_req,
  output logic [7:0]                    mem_rdata
);
  logic [13:0] prog [0:255];   // Program words, loaded by the bench.
  logic [7:0]  data [0:65535]; // Full 16-bit data space.

  // Fetch answers at once; words past the loaded area read as idle.
  always_comb begin
    if (prog_addr < 15'h0100) begin
      instr = prog[prog_addr[7:0]];
    end else begin
      instr = 14'h0000;
    end
  end

  // Without a read strobe the bus shows the inverse, so a missing strobe is seen.
  always_comb begin
    if (mem_req.re === 1'b1) begin
      mem_rdata = data[mem_req.addr];
    end else begin
      mem_rdata = ~data[mem_req.addr];
    end
  end

  // Writes land at the clock edge that ends the write cycle.
  always @(posedge mclk) begin
    if (mem_req.we === 1'b1) begin
      data[mem_req.addr] <= mem_req.wdata;
    end
  end
endmodule : cpo_mem_model

// ==== tb_cpu_control_and_pointer_ops.sv ====
/*
  Self-checking bench for the control and pointer core.
  Assumes the memory model above and the register map of the package.
*/
`timescale 1ns/1ps
module tb_cpu_control_and_pointer_ops;
  logic                     mclk = 1'b0;
  logic                     rst = 1'b1;
  logic [cpo_pkg::PC_W-1:0] prog_addr;
  logic [13:0]              instr;
  cpo_pkg::cpo_mem_req_t    mem_req;
  logic [7:0]               mem_rdata;
  logic [1:0]               reg_addr = 2'h0;
  logic [7:0]               reg_wdata = 8'h00;
  logic                     reg_wr = 1'b0;
  logic                     reg_rd = 1'b0;
  logic [7:0]               reg_rdata;
  logic                     wake = 1'b0;
  logic                     wdt_clear;
  logic                     restart;
  logic                     sleeping;
  logic [7:0]               timer_cfg;
  logic [7:0][7:0]          pin_dir;
  int                       n_errors = 0;
  int                       check_count = 0;
  int                       n_wdt = 0; // Watchdog clear pulses seen.
  int                       n_rst = 0; // Restart pulses seen.
  logic [7:0]               rd_val;

  cpo_core uut (.mclk(mclk), .rst(rst), .prog_addr(prog_addr), .instr(instr),
    .mem_req(mem_req), .mem_rdata(mem_rdata), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .wake(wake), .wdt_clear(wdt_clear), .restart(restart), .sleeping(sleeping),
    .timer_cfg(timer_cfg), .pin_dir(pin_dir));
  cpo_mem_model pm (.mclk(mclk), .prog_addr(prog_addr), .instr(instr),
    .mem_req(mem_req), .mem_rdata(mem_rdata));

  // Clock at 125 MHz.
  always #4 mclk = ~mclk;

  // Count side-effect pulses; each stands for one cycle only.
  always @(posedge mclk) begin
    if (wdt_clear === 1'b1) n_wdt <= n_wdt + 1;
    if (restart === 1'b1) n_rst <= n_rst + 1;
  end

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // Hold reset, wipe both memories and load the program from address 0.
  task automatic load(input logic [13:0] words[$]);
    @(posedge mclk);
    rst <= 1'b1;
    for (int i = 0; i < 256; i++) pm.prog[i] = 14'h0000;
    for (int i = 0; i < 65536; i++) pm.data[i] = 8'hee;
    foreach (words[i]) pm.prog[i] = words[i];
  endtask : load

  // Release reset after ten cycles; returns at the releasing edge.
  task automatic go();
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
  endtask : go

  task automatic wreg(input logic [1:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask : wreg

  // Read data is valid only in the cycle after the strobe.
  task automatic rreg(input string what, input logic [1:0] a, input logic [7:0] e);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    check(what, {8'h00, reg_rdata}, {8'h00, e});
  endtask : rreg

  // Literal AND and ADD with flags, an unknown word, and register access kinds.
  task automatic t_literals();
    load('{14'h3e8f, 14'h0007, 14'h393c, 14'h3ef4, 14'h2804});
    go();
    repeat (20) @(posedge mclk);
    rreg("acc", cpo_pkg::REG_ACC, 8'h00);
    rreg("flags", cpo_pkg::REG_FLAGS, 8'h1f);
    rreg("pc", cpo_pkg::REG_PCLO, 8'h04);
    wreg(cpo_pkg::REG_ACC, 8'h77);
    rreg("acc_ro", cpo_pkg::REG_ACC, 8'h00);
    wreg(cpo_pkg::REG_CTRL, 8'h00);
    rreg("ctrl", cpo_pkg::REG_CTRL, 8'h00);
  endtask : t_literals

  // Relative branches forward, by accumulator, and back onto itself.
  task automatic t_branches();
    int n;
    load('{14'h3203, 14'h3e10, 14'h3e10, 14'h3e10, 14'h3e02, 14'h000b,
           14'h3e10, 14'h3e10, 14'h33ff});
    go();
    n = 0;
    #1;
    while (prog_addr !== 15'h0008 && n < 20) begin
      @(posedge mclk);
      #1;
      n++;
    end
    check("edges_to_target", 16'(n), 16'h0004);
    repeat (10) @(posedge mclk);
    rreg("acc", cpo_pkg::REG_ACC, 8'h02);
    rreg("pc", cpo_pkg::REG_PCLO, 8'h08);
  endtask : t_branches

  // Nested calls and all three returns through the return stack.
  task automatic t_calls();
    load('{14'h2010, 14'h000a, 14'h3e01, 14'h2803});
    pm.prog[8'h10] = 14'h3e20;
    pm.prog[8'h11] = 14'h2018;
    pm.prog[8'h12] = 14'h0008;
    pm.prog[8'h18] = 14'h0009;
    pm.prog[8'h20] = 14'h3444;
    go();
    repeat (40) @(posedge mclk);
    rreg("acc", cpo_pkg::REG_ACC, 8'h45);
    rreg("pc", cpo_pkg::REG_PCLO, 8'h03);
  endtask : t_calls

  // Pointer updates in post-increment, pre-decrement and post-decrement modes, wrap below zero, indexed access.
  task automatic t_pointers();
    load('{14'h3e11, 14'h001a, 14'h3e11, 14'h0019, 14'h3160, 14'h3fdf,
           14'h0013, 14'h3f3f, 14'h2808});
    pm.data[16'h0001] = 8'ha5;
    pm.data[16'hfffe] = 8'h00;
    go();
    repeat (40) @(posedge mclk);
    check("mem0", {8'h00, pm.data[16'h0000]}, 16'h0022);
    check("mem1", {8'h00, pm.data[16'h0001]}, 16'h00a5);
    check("memffff", {8'h00, pm.data[16'hffff]}, 16'h0022);
    rreg("acc", cpo_pkg::REG_ACC, 8'h00);
    rreg("flags", cpo_pkg::REG_FLAGS, 8'h1c);
    rreg("pc", cpo_pkg::REG_PCLO, 8'h08);
  endtask : t_pointers

  // File AND both ways, timer and pin loads, watchdog, standby, restart.
  task automatic t_inherent();
    load('{14'h3e3c, 14'h05a0, 14'h0521, 14'h0062, 14'h0065, 14'h0064,
           14'h0063, 14'h0001, 14'h2808});
    pm.data[16'h0020] = 8'hf5;
    pm.data[16'h0021] = 8'h0f;
    go();
    repeat (20) @(posedge mclk);
    check("file20", {8'h00, pm.data[16'h0020]}, 16'h0034);
    rreg("acc", cpo_pkg::REG_ACC, 8'h0c);
    check("timer_cfg", {8'h00, timer_cfg}, 16'h000c);
    check("pin_dir5", {8'h00, pin_dir[5]}, 16'h000c);
    check("pin_dir4", {8'h00, pin_dir[4]}, 16'h0000);
    check("wdt_pulses", 16'(n_wdt), 16'h0001);
    check("sleeping", {15'h0000, sleeping}, 16'h0001);
    rreg("flags", cpo_pkg::REG_FLAGS, 8'h10);
    @(posedge mclk);
    wake <= 1'b1;
    @(posedge mclk);
    wake <= 1'b0;
    repeat (6) @(posedge mclk);
    check("restart_seen", 16'(n_rst > 0), 16'h0001);
  endtask : t_inherent

  task automatic print_verdict();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : print_verdict

  // Main sequence.
  initial begin
    t_literals();
    t_branches();
    t_calls();
    t_pointers();
    t_inherent();
    print_verdict();
  end

  // The tests need well under 5000 cycles; 50 us means a hang.
  initial begin
    #50000;
    n_errors++;
    print_verdict();
  end
endmodule : tb_cpu_control_and_pointer_ops
